// ==== rtl/dbsp_serial_ports.sv ====
/*
  Dual software-driven serial port: two open-drain clock/data pairs
  controlled by two port control registers on an Avalon-MM slave.
  Assumes external pullups on all four lines, a free running link clock
  for the pin logic, and a master that holds its request while
  waitrequest is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbsp_params.svh"

module dbsp_serial_ports (
   // System clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Link clock for the pin logic
   input wire logic linkClk,
   // Avalon-MM slave
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   // Port one clock line
   input wire logic serialClockLineOneIn,
   output logic serialClockLineOneOut,
   output logic serialClockLineOneOeN,
   // Port one data line
   input wire logic serialDataLineOneIn,
   output logic serialDataLineOneOut,
   output logic serialDataLineOneOeN,
   // Port two clock line
   input wire logic serialClockLineTwoIn,
   output logic serialClockLineTwoOut,
   output logic serialClockLineTwoOeN,
   // Port two data line
   input wire logic serialDataLineTwoIn,
   output logic serialDataLineTwoOut,
   output logic serialDataLineTwoOeN
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------

   // A line is pulled low only when its port is on and the bit is zero
   function automatic logic pullLow(input logic enable, input logic outBit);
      pullLow = enable & ~outBit;
   endfunction

   // Merge a byte-lane write into a control register, writable bits only
   function automatic logic [7:0] mergeCtrl(input logic [7:0] oldVal,
                                            input logic [7:0] newVal);
      mergeCtrl = (oldVal & ~`DBSP_WR_MASK) | (newVal & `DBSP_WR_MASK);
   endfunction

   // Read view of a control register: sensed levels only while enabled
   function automatic logic [7:0] ctrlView(input logic [7:0] ctrl,
                                           input logic clkLevel,
                                           input logic datLevel);
      logic [7:0] view;
      view = ctrl & `DBSP_WR_MASK;
      view[`DBSP_BIT_CLK_IN] = ctrl[`DBSP_BIT_ENABLE] & clkLevel;
      view[`DBSP_BIT_DAT_IN] = ctrl[`DBSP_BIT_ENABLE] & datLevel;
      ctrlView = view;
   endfunction

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   dbsp_pkg::dbsp_bus_state_t busState_q;
   dbsp_pkg::dbsp_bus_state_t busState_d;
   logic [7:0] portOneCtrl_q;
   logic [7:0] portOneCtrl_d;
   logic [7:0] portTwoCtrl_q;
   logic [7:0] portTwoCtrl_d;
   logic [31:0] readdata_q;
   logic [31:0] readdata_d;
   logic waitrequest_q;
   logic waitrequest_d;
   logic [1:0] response_q;
   logic [1:0] response_d;
   logic linkRstMeta_q;
   logic linkRstN_q;
   logic [3:0] pinLevelLink;
   logic [3:0] pinLevelSys;
   logic [3:0] pullCmdSys;
   logic [3:0] pullCmdLink;
   logic [3:0] pullCmd_q;
   logic [3:0] pullState_q;
   logic [3:0] lineOeN_q;
   logic [3:0] pullStateSys;
   logic [3:0] pinRaw;
   logic request;
   logic hitPortOne;
   logic hitPortTwo;
   logic hitDrive;
   logic hitAny;
   logic lowLane;
   logic commitWrite;
   logic [7:0] portOneView;
   logic [7:0] portTwoView;
   logic [31:0] readSel;

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------

   // One request is live while read or write stands
   assign request = read | write;
   assign hitPortOne = (address == `DBSP_OFS_PORT_ONE);
   assign hitPortTwo = (address == `DBSP_OFS_PORT_TWO);
   assign hitDrive = (address == `DBSP_OFS_DRIVE);
   assign hitAny = hitPortOne | hitPortTwo | hitDrive;
   assign lowLane = byteenable[0];

   // A write lands only at the edge that also ends the wait
   assign commitWrite = write & (busState_q == dbsp_pkg::DBSP_ST_ANSWER);

   // ----------------------------------------------------------------
   // Read selection
   // ----------------------------------------------------------------

   // Input bits show line levels after the synchronisers
   assign portOneView = ctrlView(portOneCtrl_q, pinLevelSys[0],
                                 pinLevelSys[1]);
   assign portTwoView = ctrlView(portTwoCtrl_q, pinLevelSys[2],
                                 pinLevelSys[3]);

   // Decode chain; unmapped words read as zero
   always_comb begin
      if (hitPortOne) begin
         readSel = {24'h00_0000, portOneView};
      end else if (hitPortTwo) begin
         readSel = {24'h00_0000, portTwoView};
      end else if (hitDrive) begin
         readSel = {28'h000_0000, pullStateSys};
      end else begin
         readSel = `DBSP_RST_RDATA;
      end
   end

   // ----------------------------------------------------------------
   // Register slave sequencing
   // ----------------------------------------------------------------

   // Fixed answer: waitrequest drops one cycle after the request starts,
   // so every access costs exactly two cycles and the master never waits
   // on the link clock
   always_comb begin
      busState_d = busState_q;
      waitrequest_d = 1'b1;
      readdata_d = readdata_q;
      response_d = response_q;
      case (busState_q)
         dbsp_pkg::DBSP_ST_IDLE: begin
            if (request) begin
               busState_d = dbsp_pkg::DBSP_ST_ANSWER;
               waitrequest_d = 1'b0;
               readdata_d = read ? readSel : `DBSP_RST_RDATA;
               response_d = hitAny ? dbsp_pkg::DBSP_RESP_OKAY
                                   : dbsp_pkg::DBSP_RESP_DECODEERROR;
            end
         end
         dbsp_pkg::DBSP_ST_ANSWER: begin
            busState_d = dbsp_pkg::DBSP_ST_IDLE;
            readdata_d = `DBSP_RST_RDATA;
            response_d = dbsp_pkg::DBSP_RESP_OKAY;
         end
         default: begin
            busState_d = dbsp_pkg::DBSP_ST_IDLE;
         end
      endcase
   end

   // Slave state and registered answer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busState_q <= dbsp_pkg::DBSP_ST_IDLE;
         waitrequest_q <= 1'b1;
         readdata_q <= `DBSP_RST_RDATA;
         response_q <= dbsp_pkg::DBSP_RESP_OKAY;
      end else begin
         busState_q <= busState_d;
         waitrequest_q <= waitrequest_d;
         readdata_q <= readdata_d;
         response_q <= response_d;
      end
   end

   assign readdata = readdata_q;
   assign waitrequest = waitrequest_q;
   assign response = response_q;

   // ----------------------------------------------------------------
   // Port control registers
   // ----------------------------------------------------------------

   // Only bits 0, 1 and 4 store; status bits and bits 7:5 ignore writes
   assign portOneCtrl_d = (commitWrite & hitPortOne & lowLane)
                          ? mergeCtrl(portOneCtrl_q, writedata[7:0])
                          : portOneCtrl_q;
   assign portTwoCtrl_d = (commitWrite & hitPortTwo & lowLane)
                          ? mergeCtrl(portTwoCtrl_q, writedata[7:0])
                          : portTwoCtrl_q;

   // Chip reset returns both ports to released and disabled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         portOneCtrl_q <= `DBSP_RST_PORT_CTRL;
         portTwoCtrl_q <= `DBSP_RST_PORT_CTRL;
      end else begin
         portOneCtrl_q <= portOneCtrl_d;
         portTwoCtrl_q <= portTwoCtrl_d;
      end
   end

   // ----------------------------------------------------------------
   // Drive commands toward the link side
   // ----------------------------------------------------------------

   // Port one serves general peripherals, port two the monitor channel;
   // the logic treats them alike and leaves the choice to software
   assign pullCmdSys[0] = pullLow(portOneCtrl_q[`DBSP_BIT_ENABLE],
                                  portOneCtrl_q[`DBSP_BIT_CLK_OUT]);
   assign pullCmdSys[1] = pullLow(portOneCtrl_q[`DBSP_BIT_ENABLE],
                                  portOneCtrl_q[`DBSP_BIT_DAT_OUT]);
   assign pullCmdSys[2] = pullLow(portTwoCtrl_q[`DBSP_BIT_ENABLE],
                                  portTwoCtrl_q[`DBSP_BIT_CLK_OUT]);
   assign pullCmdSys[3] = pullLow(portTwoCtrl_q[`DBSP_BIT_ENABLE],
                                  portTwoCtrl_q[`DBSP_BIT_DAT_OUT]);

   // Commands leave this domain from flops only: enable and output bits
   // may change at one edge, and a gate glitch caught by the far
   // synchroniser would put a false pulse on a line
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pullCmd_q <= `DBSP_RST_DRIVE;
      end else begin
         pullCmd_q <= pullCmdSys;
      end
   end

   // ----------------------------------------------------------------
   // Link clock domain
   // ----------------------------------------------------------------

   // Local reset: asserts at once, releases on the link clock
   always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
         linkRstMeta_q <= 1'b0;
         linkRstN_q <= 1'b0;
      end else begin
         linkRstMeta_q <= 1'b1;
         linkRstN_q <= linkRstMeta_q;
      end
   end

   // Each drive bit is a slow level from software, so two flops suffice;
   // bits may land one link cycle apart, harmless for bit-banged lines
   dbsp_sync_2ff u_cmdSync (
      .clk(linkClk),
      .rstN(linkRstN_q),
      .levelIn(pullCmd_q),
      .levelOut(pullCmdLink)
   );

   // Pin drivers register the command so outputs come from flops; the
   // enables are kept in their own active-low flops so that no gate sits
   // between a flop and a pin, and the drive status keeps its own copy
   // for the readback crossing
   always_ff @(posedge linkClk or negedge linkRstN_q) begin
      if (!linkRstN_q) begin
         pullState_q <= `DBSP_RST_DRIVE;
         lineOeN_q <= `DBSP_RST_LINE_OEN;
      end else begin
         pullState_q <= pullCmdLink;
         lineOeN_q <= ~pullCmdLink;
      end
   end

   // Open drain: data is always low, enable (active low) only when pulling
   assign serialClockLineOneOut = 1'b0;
   assign serialDataLineOneOut = 1'b0;
   assign serialClockLineTwoOut = 1'b0;
   assign serialDataLineTwoOut = 1'b0;
   assign serialClockLineOneOeN = lineOeN_q[0];
   assign serialDataLineOneOeN = lineOeN_q[1];
   assign serialClockLineTwoOeN = lineOeN_q[2];
   assign serialDataLineTwoOeN = lineOeN_q[3];

   // Line levels arrive asynchronously and are caught on the link clock
   assign pinRaw = {serialDataLineTwoIn, serialClockLineTwoIn,
                    serialDataLineOneIn, serialClockLineOneIn};

   dbsp_sync_2ff u_pinSync (
      .clk(linkClk),
      .rstN(linkRstN_q),
      .levelIn(pinRaw),
      .levelOut(pinLevelLink)
   );

   // ----------------------------------------------------------------
   // Back into the system clock domain
   // ----------------------------------------------------------------

   // Second crossing of the levels before software may see them
   dbsp_sync_2ff u_levelSync (
      .clk(clk),
      .rstN(nrst),
      .levelIn(pinLevelLink),
      .levelOut(pinLevelSys)
   );

   // Drive state as actually applied, for software to confirm its writes
   dbsp_sync_2ff u_driveSync (
      .clk(clk),
      .rstN(nrst),
      .levelIn(pullState_q),
      .levelOut(pullStateSys)
   );

endmodule

`default_nettype wire

// ==== rtl/dbsp_params.svh ====
/*
  Constants of the dual serial port block: register offsets, field
  positions, reset values, the write mask and the idle read data of the register slave.
  Assumes it is included by bare name from the top module, the checker and the bench.
*/
`ifndef DBSP_PARAMS_SVH
`define DBSP_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------
`define DBSP_OFS_PORT_ONE 4'h0
`define DBSP_OFS_PORT_TWO 4'h4
`define DBSP_OFS_DRIVE 4'h8

// ----------------------------------------------------------------
// Field positions inside a port control register
// ----------------------------------------------------------------
`define DBSP_BIT_CLK_OUT 0
`define DBSP_BIT_DAT_OUT 1
`define DBSP_BIT_CLK_IN 2
`define DBSP_BIT_DAT_IN 3
`define DBSP_BIT_ENABLE 4

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define DBSP_RST_PORT_CTRL 8'h00
`define DBSP_WR_MASK 8'h13
`define DBSP_RST_DRIVE 4'h0
`define DBSP_RST_LINE_OEN 4'hf
`define DBSP_RST_RDATA 32'h0000_0000

`endif

// ==== rtl/dbsp_pkg.sv ====
/*
  Types shared by the dual serial port block.
  Stands alone; it includes no header of its own.
*/
package dbsp_pkg;

   // ----------------------------------------------------------------
   // Register slave state, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DBSP_ST_IDLE = 2'b01,
      DBSP_ST_ANSWER = 2'b10
   } dbsp_bus_state_t;

   // ----------------------------------------------------------------
   // Avalon-MM response codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DBSP_RESP_OKAY = 2'b00,
      DBSP_RESP_DECODEERROR = 2'b11
   } dbsp_resp_t;

endpackage

// ==== rtl/dbsp_sync_2ff.sv ====
/*
  Two flip-flop level synchroniser, four bits wide.
  Assumes its input is a level that stays put for several destination
  clock periods; pulses shorter than that may be lost.
*/
`timescale 1ns/1ps
`default_nettype none

module dbsp_sync_2ff (
   // Destination clock and reset
   input wire logic clk,
   input wire logic rstN,
   // Levels in and out
   input wire logic [3:0] levelIn,
   output logic [3:0] levelOut
);

   logic [3:0] stageOne_q;
   logic [3:0] stageTwo_q;

   // The first stage feeds the second stage and nothing else
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         stageOne_q <= 4'h0;
         stageTwo_q <= 4'h0;
      end else begin
         stageOne_q <= levelIn;
         stageTwo_q <= stageOne_q;
      end
   end

   assign levelOut = stageTwo_q;

endmodule

`default_nettype wire

// ==== dv/dbsp_serial_ports_chk.sv ====
/*
  Checker for the dual serial port block: bus answer, line drive, status.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbsp_params.svh"
module dbsp_serial_ports_chk (
   // Clock, reset and register bus
   input wire logic clk,
   input wire logic nrst,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response,
   // Serial lines
   input wire logic serialClockLineOneIn,
   input wire logic serialClockLineOneOut,
   input wire logic serialClockLineOneOeN,
   input wire logic serialDataLineOneIn,
   input wire logic serialDataLineOneOut,
   input wire logic serialDataLineOneOeN,
   input wire logic serialClockLineTwoIn,
   input wire logic serialClockLineTwoOut,
   input wire logic serialClockLineTwoOeN,
   input wire logic serialDataLineTwoIn,
   input wire logic serialDataLineTwoOut,
   input wire logic serialDataLineTwoOeN
);
   // -----------------------------
   // Shadow of the control registers
   // -----------------------------
   logic [7:0] oneQ, twoQ;
   logic [4:0] quietQ, lineQ;
   logic [3:0] lvlQ;
   wire wrOk = write && !waitrequest && byteenable[0];
   wire rdOk = read && !waitrequest;
   wire [3:0] lvl = {serialDataLineTwoIn, serialClockLineTwoIn,
      serialDataLineOneIn, serialClockLineOneIn};
   wire [3:0] oeN = {serialDataLineTwoOeN, serialClockLineTwoOeN,
      serialDataLineOneOeN, serialClockLineOneOeN};
   wire [3:0] outs = {serialDataLineTwoOut, serialClockLineTwoOut,
      serialDataLineOneOut, serialClockLineOneOut};
   // Released unless enabled and written zero
   wire [3:0] want = ~({twoQ[4], twoQ[4], oneQ[4], oneQ[4]} &
      ~{twoQ[1:0], oneQ[1:0]});
   // Long quiet spans hide the link-clock crossing latency
   wire settled = quietQ >= 5'h14 && lineQ >= 5'h14;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         oneQ <= 8'h00;
         twoQ <= 8'h00;
         quietQ <= 5'h00;
         lineQ <= 5'h00;
         lvlQ <= 4'hf;
      end else begin
         if (wrOk && address == `DBSP_OFS_PORT_ONE) oneQ <= writedata[7:0];
         if (wrOk && address == `DBSP_OFS_PORT_TWO) twoQ <= writedata[7:0];
         quietQ <= wrOk ? 5'h00 : quietQ + {4'h0, quietQ != 5'h1f};
         lineQ <= (lvl != lvlQ) ? 5'h00 : lineQ + {4'h0, lineQ != 5'h1f};
         lvlQ <= lvl;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_reset_lines: assert property ($rose(nrst) |-> oeN == 4'hf)
      else $error("Line pulled right after reset");
   chk_open_drain: assert property ((~oeN & outs) == 4'h0)
      else $error("Line driven high");
   chk_one_clock: assert property (settled |-> oeN[0] == want[0])
      else $error("Port one clock drive wrong");
   chk_one_data: assert property (settled |-> oeN[1] == want[1])
      else $error("Port one data drive wrong");
   chk_two_clock: assert property (settled |-> oeN[2] == want[2])
      else $error("Port two clock drive wrong");
   chk_two_data: assert property (settled |-> oeN[3] == want[3])
      else $error("Port two data drive wrong");
   chk_one_status: assert property (rdOk && settled && address == `DBSP_OFS_PORT_ONE
      |-> readdata[3:2] == (oneQ[4] ? lvl[1:0] : 2'b00)) else $error("Port one status wrong");
   chk_two_status: assert property (rdOk && settled && address == `DBSP_OFS_PORT_TWO
      |-> readdata[3:2] == (twoQ[4] ? lvl[3:2] : 2'b00)) else $error("Port two status wrong");
   chk_answer_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("Answer longer than one cycle");
   chk_unmapped_read: assert property (rdOk && address > `DBSP_OFS_DRIVE
      |-> response == 2'b11 && readdata == 32'h0) else $error("Unmapped read answered");
   cover property (rdOk && readdata[2]);
   cover property ($fell(serialClockLineTwoOeN));
   cover property (response == 2'b11);
endmodule
`default_nettype wire

// ==== dv/dbsp_bus_partner.sv ====
/*
  Far side of the four lines: pullups plus remote devices that may hold
  a line low. Assumes the device only pulls low or releases.
*/
`timescale 1ns/1ps
`default_nettype none
module dbsp_bus_partner (
   // Device pins, order clock one, data one, clock two, data two
   input wire logic [3:0] oeN,
   input wire logic [3:0] drv,
   // Remote peripheral (port one) or monitor (port two) pulling low
   input wire logic [3:0] holdLow,
   // Resolved line levels
   output logic [3:0] level
);
   // Wired-AND: a released line floats up by its resistor
   assign level = ~((~oeN & ~drv) | holdLow);
endmodule
`default_nettype wire

// ==== dv/dbsp_serial_ports_tb.sv ====
/*
  Bench for the dual serial port block: register accesses over the bus,
  line drive and line sensing. Assumes the checker and partner files.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbsp_params.svh"
module dbsp_serial_ports_tb;
   logic clk = 1'b0, linkClk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
   logic [3:0] address = 4'h0, byteenable = 4'h0, holdLow = 4'h0;
   logic [31:0] writedata = 32'h0, rd;
   logic [1:0] rs;
   logic [7:0] vals [9] = '{8'h00, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13, 8'h13, 8'h13, 8'hef};
   logic [1:0] holds [9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
   wire [31:0] readdata;
   wire waitrequest;
   wire [1:0] response;
   wire [3:0] lvl, oeN, drv;
   int fails = 0, checks_done = 0, cycles = 0;
   // Link clock offset so the two domains never line up
   initial forever #25 clk = ~clk;
   initial begin
      #13;
      forever #40 linkClk = ~linkClk;
   end
   dbsp_serial_ports uut (.clk(clk), .nrst(nrst), .linkClk(linkClk), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest), .response(response),
      .serialClockLineOneIn(lvl[0]), .serialClockLineOneOut(drv[0]),
      .serialClockLineOneOeN(oeN[0]), .serialDataLineOneIn(lvl[1]),
      .serialDataLineOneOut(drv[1]), .serialDataLineOneOeN(oeN[1]),
      .serialClockLineTwoIn(lvl[2]), .serialClockLineTwoOut(drv[2]),
      .serialClockLineTwoOeN(oeN[2]), .serialDataLineTwoIn(lvl[3]),
      .serialDataLineTwoOut(drv[3]), .serialDataLineTwoOeN(oeN[3]));
   dbsp_bus_partner partner (.oeN(oeN), .drv(drv), .holdLow(holdLow), .level(lvl));
   // -----------------------------
   // Bus, compare and closing tasks
   // -----------------------------
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteenable <= be;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 40);
      rd = readdata;
      rs = response;
      read <= 1'b0;
      write <= 1'b0;
      if (n >= 40) begin
         fails++;
         $display("[FAIL] %0t ns: no bus answer", $time);
      end
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Released (1) unless enabled and written zero: data, clock
   function automatic logic [1:0] rel(input logic [7:0] v);
      return ~({v[4], v[4]} & ~v[1:0]);
   endfunction
   // Readback: RW bits 0, 1, 4; levels only while enabled
   function automatic logic [31:0] rdExp(input logic [7:0] v, input logic [1:0] lv);
      return {27'h0, v[4], v[4] ? lv : 2'b00, v[1:0]};
   endfunction
   // Hang guard, well above the some 700 cycles the tests use
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         fails++;
         $display("[FAIL] %0t ns: run did not finish", $time);
         close_out();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      xfer(0, `DBSP_OFS_PORT_ONE, 32'h0, 4'hf);
      check(rd, 32'h0);
      xfer(0, `DBSP_OFS_PORT_TWO, 32'h0, 4'hf);
      check(rd, 32'h0);
      check({28'h0, oeN}, 32'hf);
      $display("reset values done");
      // Every drive combination, remote hold-low, disabled and read-only bits
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 9; i++) begin
            xfer(1, p ? `DBSP_OFS_PORT_TWO : `DBSP_OFS_PORT_ONE, {24'h0, vals[i]}, 4'hf);
            holdLow <= {2'b00, holds[i]} << (2 * p);
            repeat (24) @(posedge clk);
            xfer(0, p ? `DBSP_OFS_PORT_TWO : `DBSP_OFS_PORT_ONE, 32'h0, 4'hf);
            check(rd, rdExp(vals[i] & 8'h13, rel(vals[i]) & ~holds[i]));
            check({30'h0, oeN[2 * p +: 2]}, {30'h0, rel(vals[i])});
            check({30'h0, oeN[2 * (1 - p) +: 2]}, 32'h3);
            xfer(0, `DBSP_OFS_DRIVE, 32'h0, 4'hf);
            check(rd, {28'h0, {2'b00, ~rel(vals[i])} << (2 * p)});
         end
      end
      $display("drive and sense done");
      // Refused writes: no low byte enable, unmapped address
      xfer(1, `DBSP_OFS_PORT_ONE, 32'h10, 4'hf);
      xfer(1, `DBSP_OFS_PORT_ONE, 32'h13, 4'he);
      xfer(1, 4'hc, 32'h13, 4'hf);
      xfer(0, 4'hc, 32'h0, 4'hf);
      check({30'h0, rs}, 32'h3);
      check(rd, 32'h0);
      repeat (24) @(posedge clk);
      xfer(0, `DBSP_OFS_PORT_ONE, 32'h0, 4'hf);
      check(rd, 32'h10);
      check({28'h0, oeN}, 32'hc);
      $display("refusals done");
      // Reset in mid-run while port one pulls both lines
      @(posedge clk);
      nrst <= 1'b0;
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      xfer(0, `DBSP_OFS_PORT_ONE, 32'h0, 4'hf);
      check(rd, 32'h0);
      check({28'h0, oeN}, 32'hf);
      $display("second reset done");
      close_out();
   end
endmodule
bind dbsp_serial_ports dbsp_serial_ports_chk chk (.clk, .nrst, .address, .read, .write,
   .writedata, .byteenable, .readdata, .waitrequest, .response,
   .serialClockLineOneIn, .serialClockLineOneOut, .serialClockLineOneOeN,
   .serialDataLineOneIn, .serialDataLineOneOut, .serialDataLineOneOeN,
   .serialClockLineTwoIn, .serialClockLineTwoOut, .serialClockLineTwoOeN,
   .serialDataLineTwoIn, .serialDataLineTwoOut, .serialDataLineTwoOeN);
`default_nettype wire
